// ===== hw/mdc_defines.svh
// Offsets, field positions, reset values and timing constants of the drive configuration bank.
`ifndef MDC_DEFINES_SVH
`define MDC_DEFINES_SVH

`define MDC_ADDR_DRIVE_CFG      8'h95
`define MDC_ADDR_DETECT_CFG     8'h96
`define MDC_RESET_DRIVE_CFG     16'h0000
`define MDC_RESET_DETECT_CFG    16'h0000
`define MDC_DETECT_CFG_RSVD_BIT 7
`define MDC_DETECT_CFG_WMASK    16'hFF7F

`define MDC_CLK_MHZ             125
`define MDC_DEAD_STEP_NS        40
`define MDC_DEAD_STEP_CYC       ((`MDC_DEAD_STEP_NS * `MDC_CLK_MHZ) / 1000)
`define MDC_PWM_SLOW_KHZ        25
`define MDC_PWM_FAST_KHZ        50
`define MDC_PWM_SLOW_CYC        ((`MDC_CLK_MHZ * 1000) / `MDC_PWM_SLOW_KHZ)
`define MDC_PWM_FAST_CYC        ((`MDC_CLK_MHZ * 1000) / `MDC_PWM_FAST_KHZ)

`define MDC_THR_RANGE_BIT       4
`define MDC_THR_LO_STEP_MHZ     800
`define MDC_THR_HI_STEP_MHZ     12800

`define MDC_DUTY_FLOOR_LO_PM    50
`define MDC_DUTY_FLOOR_HI_PM    100
`define MDC_DUTY_CUTOFF_PM      15

`endif

// ===== hw/mdc_pkg.sv
// Types shared by the drive configuration bank.
`default_nettype none
package mdc_pkg;

    typedef struct packed {
        logic       speed_source_select;
        logic       output_frequency_select;
        logic [1:0] abnormal_constant_threshold;
        logic       inductive_surge_protect_enable;
        logic       mechanical_surge_protect_enable;
        logic       mechanical_surge_mode;
        logic       position_detect_release_mode;
        logic       closed_loop_disable;
        logic [2:0] closed_loop_acceleration;
        logic [1:0] minimum_duty_field;
        logic [1:0] phase_slew_control;
    } mdc_drive_cfg_s;

    typedef struct packed {
        logic [1:0] advance_angle;
        logic [3:0] position_detect_current_threshold;
        logic [1:0] sense_clock_select;
        logic       reserved;
        logic [1:0] control_loop_constant;
        logic [4:0] bridge_dead_time;
    } mdc_detect_cfg_s;

    typedef struct packed {
        logic        speed_from_pwm;
        logic [12:0] pwm_period_cycles;
        logic [1:0]  kt_high_x2;
        logic [1:0]  kt_low_x4;
        logic        inductive_surge_on;
        logic        mechanical_surge_on;
        logic        surge_to_fixed_24v;
        logic        release_to_hiz;
        logic        closed_loop_allowed;
        logic [2:0]  accel_code;
        logic        accel_immediate;
        logic [6:0]  duty_floor_permille;
        logic        low_cmd_full_duty;
        logic [1:0]  slew_rate_index;
    } mdc_drive_set_s;

    typedef struct packed {
        logic [6:0]  advance_degrees;
        logic        skip_position_detect;
        logic [4:0]  sense_current_x200ma;
        logic [1:0]  sense_rate_shift;
        logic [2:0]  loop_gain_quarters;
        logic [10:0] dead_time_cycles;
    } mdc_detect_set_s;

endpackage : mdc_pkg

`default_nettype wire

// ===== hw/mdc_cfg_word.sv
// One writable configuration word with per-bit write mask.
`timescale 1ns/100ps
`default_nettype none

module mdc_cfg_word #(
    parameter logic [15:0] RESET_VALUE = 16'h0000,
    parameter logic [15:0] WRITE_MASK  = 16'hFFFF
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_data,
    output logic      [15:0] word_r
);

    // Masked bits keep their reset value, so read-only bits can never be set.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            word_r <= RESET_VALUE;
        else if (wr_en)
            word_r <= (wr_data & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
    end

endmodule : mdc_cfg_word

`default_nettype wire

// ===== hw/mdc_bank.sv
// Drive configuration bank: two configuration words and their decoded settings.
//
// What this block does
// (RULE1) Speed source bit picks analog or pulse input.
// (RULE2) Frequency bit picks 25 or 50 kHz.
// (RULE3) Two-bit field sets lock-detect constant window.
// (RULE4) Inductive surge enable bit switches protection.
// (RULE5) Mechanical surge enable bit switches protection.
// (RULE6) Surge mode clamps to supply or 24 V.
// (RULE7) Release mode picks braking or high impedance.
// (RULE8) Closed-loop disable keeps drive in open loop.
// (RULE9) Acceleration field limits rate; zero is immediate.
// (RULE10) Duty floor is 5 or 10 percent.
// (RULE11) Commands below 1.5 percent give 0 or 100.
// (RULE12) Slew field selects four rising edge rates.
// (RULE13) Advance angle 30, 60, 90 or 120 degrees.
// (RULE14) Zero current threshold skips detection, aligns instead.
// (RULE15) Threshold code sets sense current in steps.
// (RULE16) Sense clock field doubles rate, halves resolution.
// (RULE17) Reserved bit 7 ignored and reads zero.
// (RULE18) Loop constant field sets gain in quarters.
// (RULE19) Dead time is code plus one times 40 ns.
// (RULE20) Both words reset to zero; second at 0x96.
// (RULE21) Closed-loop threshold speed from five-bit code.
// (RULE22) Settings take effect the cycle after write.
`timescale 1ns/100ps
`default_nettype none
`include "mdc_defines.svh"

module mdc_bank (
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic                   reg_wr_en,
    input  wire logic                   reg_rd_en,
    input  wire logic [7:0]             reg_addr,
    input  wire logic [15:0]            reg_wr_data,
    input  wire logic [4:0]             open_to_closed_threshold,
    output logic      [15:0]            reg_rd_data,
    output logic                        reg_rd_valid,
    output mdc_pkg::mdc_drive_set_s     drive_set,
    output mdc_pkg::mdc_detect_set_s    detect_set,
    output logic      [17:0]            closed_loop_speed_mhz
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------

    logic [15:0]              drive_word;
    logic [15:0]              detect_word;
    mdc_pkg::mdc_drive_cfg_s  drive_cfg;
    mdc_pkg::mdc_detect_cfg_s detect_cfg;
    logic                     wr_drive;
    logic                     wr_detect;

    // Address decode; writes to any other address are dropped.
    assign wr_drive  = reg_wr_en && (reg_addr == `MDC_ADDR_DRIVE_CFG);
    assign wr_detect = reg_wr_en && (reg_addr == `MDC_ADDR_DETECT_CFG);

    // (RULE20) reset both words
    mdc_cfg_word #(
        .RESET_VALUE (`MDC_RESET_DRIVE_CFG),
        .WRITE_MASK  (16'hFFFF)
    ) u_drive_word (
        .clk     (clk),
        .reset_n (reset_n),
        .wr_en   (wr_drive),
        .wr_data (reg_wr_data),
        .word_r  (drive_word)
    );

    // (RULE17) reserved bit masked
    mdc_cfg_word #(
        .RESET_VALUE (`MDC_RESET_DETECT_CFG),
        .WRITE_MASK  (`MDC_DETECT_CFG_WMASK)
    ) u_detect_word (
        .clk     (clk),
        .reset_n (reset_n),
        .wr_en   (wr_detect),
        .wr_data (reg_wr_data),
        .word_r  (detect_word)
    );

    assign drive_cfg  = mdc_pkg::mdc_drive_cfg_s'(drive_word);
    assign detect_cfg = mdc_pkg::mdc_detect_cfg_s'(detect_word);

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------

    // Reads answer one cycle later; unmapped addresses read as zero.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            reg_rd_data  <= 16'h0000;
            reg_rd_valid <= 1'b0;
        end
        else
        begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en)
            begin
                case (reg_addr)
                    `MDC_ADDR_DRIVE_CFG:  reg_rd_data <= drive_word;
                    `MDC_ADDR_DETECT_CFG: reg_rd_data <= detect_word;
                    default:              reg_rd_data <= 16'h0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Drive word decode
    // ------------------------------------------------------------

    mdc_pkg::mdc_drive_set_s drive_nxt;

    // Pure decode of the stored word; registered below.
    always_comb
    begin
        drive_nxt = '0;
        // (RULE1) speed source
        drive_nxt.speed_from_pwm = drive_cfg.speed_source_select;
        // (RULE2) bridge switching rate
        drive_nxt.pwm_period_cycles = drive_cfg.output_frequency_select ?
            13'(`MDC_PWM_FAST_CYC) : 13'(`MDC_PWM_SLOW_CYC);
        // (RULE3) lock window: high in halves, low in quarters
        drive_nxt.kt_high_x2 = drive_cfg.abnormal_constant_threshold[0] ? 2'h0 : 2'h3;
        drive_nxt.kt_low_x4  = drive_cfg.abnormal_constant_threshold[1] ? 2'h2 : 2'h3;
        // (RULE4) inductive surge protection
        drive_nxt.inductive_surge_on = drive_cfg.inductive_surge_protect_enable;
        // (RULE5) mechanical surge protection
        drive_nxt.mechanical_surge_on = drive_cfg.mechanical_surge_protect_enable;
        // (RULE6) clamp reference
        drive_nxt.surge_to_fixed_24v = drive_cfg.mechanical_surge_mode;
        // (RULE7) release behaviour
        drive_nxt.release_to_hiz = drive_cfg.position_detect_release_mode;
        // (RULE8) closed-loop transfer
        drive_nxt.closed_loop_allowed = ~drive_cfg.closed_loop_disable;
        // (RULE9) acceleration limit
        drive_nxt.accel_code      = drive_cfg.closed_loop_acceleration;
        drive_nxt.accel_immediate = (drive_cfg.closed_loop_acceleration == 3'h0);
        // (RULE10) duty floor
        drive_nxt.duty_floor_permille = drive_cfg.minimum_duty_field[0] ?
            7'(`MDC_DUTY_FLOOR_HI_PM) : 7'(`MDC_DUTY_FLOOR_LO_PM);
        // (RULE11) below-cutoff behaviour
        drive_nxt.low_cmd_full_duty = drive_cfg.minimum_duty_field[1];
        // (RULE12) slew index, 0 slowest
        drive_nxt.slew_rate_index = drive_cfg.phase_slew_control;
    end

    // A high-window value of 0 stands for 2x: four halves wrap to zero in two bits.
    // ------------------------------------------------------------
    // Detect word decode
    // ------------------------------------------------------------

    mdc_pkg::mdc_detect_set_s detect_nxt;

    // The reserved bit is never consulted here.
    always_comb
    begin
        detect_nxt = '0;
        // (RULE13) advance angle
        detect_nxt.advance_degrees = 7'(({5'h00, detect_cfg.advance_angle} + 7'h01) * 7'h1E);
        // (RULE14) align-and-go when zero
        detect_nxt.skip_position_detect = (detect_cfg.position_detect_current_threshold == 4'h0);
        // (RULE15) sense current in 0.2 A units
        if (detect_cfg.position_detect_current_threshold == 4'h0)
            detect_nxt.sense_current_x200ma = 5'h00;
        else if (detect_cfg.position_detect_current_threshold == 4'h1)
            detect_nxt.sense_current_x200ma = 5'h02;
        else
            detect_nxt.sense_current_x200ma = {1'b0, detect_cfg.position_detect_current_threshold} + 5'h01;
        // (RULE16) rate doubles per step
        detect_nxt.sense_rate_shift = detect_cfg.sense_clock_select;
        // (RULE18) gain in quarters
        detect_nxt.loop_gain_quarters = {1'b0, detect_cfg.control_loop_constant} + 3'h1;
        // (RULE19) dead time in clock cycles
        detect_nxt.dead_time_cycles = 11'(({6'h00, detect_cfg.bridge_dead_time} + 11'h001)
            * 11'(`MDC_DEAD_STEP_CYC));
    end

    // ------------------------------------------------------------
    // Threshold speed decode
    // ------------------------------------------------------------

    logic [17:0] speed_nxt;

    // (RULE21) two ranges of threshold speed
    always_comb
    begin
        if (open_to_closed_threshold[`MDC_THR_RANGE_BIT])
            speed_nxt = 18'(({14'h0000, open_to_closed_threshold[3:0]} + 18'h00001)
                * 18'(`MDC_THR_HI_STEP_MHZ));
        else
            speed_nxt = 18'({14'h0000, open_to_closed_threshold[3:0]} * 18'(`MDC_THR_LO_STEP_MHZ));
    end

    // ------------------------------------------------------------
    // Registered settings
    // ------------------------------------------------------------

    // (RULE22) settings follow write by one cycle
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            drive_set             <= '0;
            detect_set            <= '0;
            closed_loop_speed_mhz <= 18'h00000;
        end
        else
        begin
            drive_set             <= drive_nxt;
            detect_set            <= detect_nxt;
            closed_loop_speed_mhz <= speed_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    property p_write_applies;
        @(posedge clk) disable iff (!reset_n)
        wr_drive |=> ##1 (drive_set.speed_from_pwm == $past(reg_wr_data[15], 2));
    endproperty
    a_write_applies: assert property (p_write_applies) else $error("speed source not applied"); // (RULE22)

    property p_rsvd_zero;
        @(posedge clk) disable iff (!reset_n)
        reg_rd_valid && ($past(reg_addr) == `MDC_ADDR_DETECT_CFG) |-> !reg_rd_data[7];
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read as one"); // (RULE17)

    property p_freq;
        @(posedge clk) disable iff (!reset_n)
        reset_n |=> (drive_set.pwm_period_cycles == ($past(drive_word[14]) ? 13'd2500 : 13'd5000));
    endproperty
    a_freq: assert property (p_freq) else $error("pwm period wrong"); // (RULE2)

    property p_dead;
        @(posedge clk) disable iff (!reset_n)
        reset_n |=> (detect_set.dead_time_cycles == 11'(($past(detect_word[4:0]) + 6'd1) * 5));
    endproperty
    a_dead: assert property (p_dead) else $error("dead time wrong"); // (RULE19)

    property p_skip;
        @(posedge clk) disable iff (!reset_n)
        reset_n |=> (detect_set.skip_position_detect == ($past(detect_word[13:10]) == 4'h0));
    endproperty
    a_skip: assert property (p_skip) else $error("skip detect wrong"); // (RULE14)

    property p_closed;
        @(posedge clk) disable iff (!reset_n)
        reset_n |=> (drive_set.closed_loop_allowed != $past(drive_word[7]));
    endproperty
    a_closed: assert property (p_closed) else $error("closed-loop enable wrong"); // (RULE8)

    property p_advance;
        @(posedge clk) disable iff (!reset_n)
        reset_n |=> (detect_set.advance_degrees == 7'(($past(detect_word[15:14]) + 3'd1) * 30));
    endproperty
    a_advance: assert property (p_advance) else $error("advance angle wrong"); // (RULE13)

    property p_reset_zero;
        @(posedge clk)
        !reset_n |=> (drive_word == 16'h0000) && (detect_word == 16'h0000);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("words not zero after reset"); // (RULE20)

    property p_speed;
        @(posedge clk) disable iff (!reset_n)
        reset_n && !open_to_closed_threshold[4] |=>
            (closed_loop_speed_mhz == 18'($past(open_to_closed_threshold[3:0]) * 800));
    endproperty
    a_speed: assert property (p_speed) else $error("threshold speed wrong"); // (RULE21)

endmodule : mdc_bank

`default_nettype wire

// ===== bench/mdc_host_model.sv
// Host model that drives the configuration bank's register strobes.
`timescale 1ns/100ps
`default_nettype none
`include "mdc_defines.svh"

module mdc_host_model (
    input  wire logic        clk,
    output logic             reg_wr_en,
    output logic             reg_rd_en,
    output logic [7:0]       reg_addr,
    output logic [15:0]      reg_wr_data,
    input  wire logic [15:0] reg_rd_data,
    input  wire logic        reg_rd_valid
);
    // The bus idles with both strobes low from time zero.
    initial
    begin
        reg_wr_en   = 1'b0;
        reg_rd_en   = 1'b0;
        reg_addr    = 8'h00;
        reg_wr_data = 16'h0000;
    end

    // One-cycle write; released lines show the inverse so stale data is never reused.
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic raw);
        @(posedge clk);
        reg_addr    <= a;
        reg_wr_data <= (a == `MDC_ADDR_DETECT_CFG && !raw) ? (d & `MDC_DETECT_CFG_WMASK) : d;
        reg_wr_en   <= 1'b1;
        @(posedge clk);
        reg_wr_en   <= 1'b0;
        reg_addr    <= ~a;
        reg_wr_data <= ~d;
    endtask : wr

    // One-cycle read, then a bounded wait for the valid pulse.
    task automatic rd(input logic [7:0] a, output logic [15:0] q, output logic ok);
        int n;
        ok = 1'b0;
        q  = 16'h0000;
        @(posedge clk);
        reg_addr  <= a;
        reg_rd_en <= 1'b1;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        reg_addr  <= ~a;
        for (n = 0; n < 8 && !ok; n++)
        begin
            @(posedge clk);
            if (reg_rd_valid === 1'b1)
            begin
                ok = 1'b1;
                q  = reg_rd_data;
            end
        end
    endtask : rd
endmodule : mdc_host_model
`default_nettype wire

// ===== bench/mdc_bank_tb_top.sv
// Self-checking bench for the drive configuration bank.
`timescale 1ns/100ps
`default_nettype none
`include "mdc_defines.svh"

module mdc_bank_tb_top;
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] data;
        logic [4:0]  thr;
        logic [15:0] exp_rd;
        logic [17:0] exp_speed;
    } mdc_row_s;

    logic                     clk;
    logic                     reset_n;
    logic                     reg_wr_en;
    logic                     reg_rd_en;
    logic [7:0]               reg_addr;
    logic [15:0]              reg_wr_data;
    logic [4:0]               open_to_closed_threshold;
    logic [15:0]              reg_rd_data;
    logic                     reg_rd_valid;
    mdc_pkg::mdc_drive_set_s  drive_set;
    mdc_pkg::mdc_detect_set_s detect_set;
    logic [17:0]              closed_loop_speed_mhz;
    int                       fails;
    int                       total_checks;
    logic [15:0]              drive_w;
    logic [15:0]              detect_w;
    mdc_row_s                 rows [14];

    mdc_bank uut (.clk(clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .open_to_closed_threshold(open_to_closed_threshold),
        .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .drive_set(drive_set),
        .detect_set(detect_set), .closed_loop_speed_mhz(closed_loop_speed_mhz));

    mdc_host_model host (.clk(clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid));

    // Free-running 125 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Expected decode, worked out independently of the design.
    // ------------------------------------------------------------
    // drive decode
    function automatic mdc_pkg::mdc_drive_set_s exp_drive(input logic [15:0] w);
        mdc_pkg::mdc_drive_set_s s;
        s.speed_from_pwm      = w[15];
        s.pwm_period_cycles   = w[14] ? 13'h09C4 : 13'h1388;
        s.kt_high_x2          = w[12] ? 2'h0 : 2'h3;
        s.kt_low_x4           = w[13] ? 2'h2 : 2'h3;
        s.inductive_surge_on  = w[11];
        s.mechanical_surge_on = w[10];
        s.surge_to_fixed_24v  = w[9];
        s.release_to_hiz      = w[8];
        s.closed_loop_allowed = ~w[7];
        s.accel_code          = w[6:4];
        s.accel_immediate     = (w[6:4] == 3'h0);
        s.duty_floor_permille = w[2] ? 7'h64 : 7'h32;
        s.low_cmd_full_duty   = w[3];
        s.slew_rate_index     = w[1:0];
        return s;
    endfunction : exp_drive

    function automatic mdc_pkg::mdc_detect_set_s exp_detect(input logic [15:0] w);
        mdc_pkg::mdc_detect_set_s s;
        s.advance_degrees      = 7'h1E * (7'(w[15:14]) + 7'h01);
        s.skip_position_detect = (w[13:10] == 4'h0);
        s.sense_current_x200ma = (w[13:10] < 4'h2) ? {w[13:10], 1'b0} : 5'(w[13:10]) + 5'h01;
        s.sense_rate_shift     = w[9:8];
        s.loop_gain_quarters   = 3'(w[6:5]) + 3'h1;
        s.dead_time_cycles     = 11'h005 * (11'(w[4:0]) + 11'h001);
        return s;
    endfunction : exp_detect

    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict

    task automatic check_settings;
        check("drive_set", 40'(drive_set), 40'(exp_drive(drive_w)));
        check("detect_set", 40'(detect_set), 40'(exp_detect(detect_w)));
    endtask : check_settings

    // A missing valid pulse ends the run at once, since later reads would be meaningless.
    task automatic read_check(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] q;
        logic        ok;
        host.rd(a, q, ok);
        check("read valid", 40'(ok), 40'h1);
        if (!ok)
            give_verdict();
        else
            check("read data", 40'(q), 40'(exp));
    endtask : read_check

    // Reset check first, then table rows, timing, refusal, reserved-bit and mid-run reset cases.
    initial
    begin
        fails        = 0;
        total_checks = 0;
        reset_n      = 1'b0;
        open_to_closed_threshold = 5'h00;
        drive_w      = `MDC_RESET_DRIVE_CFG;
        detect_w     = `MDC_RESET_DETECT_CFG;
        rows = '{'{8'h95, 16'h0000, 5'h00, 16'h0000, 18'h00000}, '{8'h95, 16'h5555, 5'h01, 16'h5555, 18'h00320},
                 '{8'h95, 16'hAAAA, 5'h0F, 16'hAAAA, 18'h02EE0}, '{8'h95, 16'hFFFF, 5'h10, 16'hFFFF, 18'h03200},
                 '{8'h95, 16'h8010, 5'h11, 16'h8010, 18'h06400}, '{8'h95, 16'h4040, 5'h1F, 16'h4040, 18'h32000},
                 '{8'h95, 16'h2460, 5'h07, 16'h2460, 18'h015E0}, '{8'h95, 16'h1234, 5'h08, 16'h1234, 18'h01900},
                 '{8'h96, 16'h5555, 5'h18, 16'h5555, 18'h1C200}, '{8'h96, 16'hAAAA, 5'h02, 16'hAA2A, 18'h00640},
                 '{8'h96, 16'hFFFF, 5'h0A, 16'hFF7F, 18'h01F40}, '{8'h96, 16'h0400, 5'h03, 16'h0400, 18'h00960},
                 '{8'h96, 16'h0800, 5'h04, 16'h0800, 18'h00C80}, '{8'h96, 16'h0000, 5'h00, 16'h0000, 18'h00000}};
        repeat (20) @(posedge clk);
        #1;
        check("drive_set in reset", 40'(drive_set), 40'h0);
        @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check_settings();
        foreach (rows[i])
        begin
            @(posedge clk);
            open_to_closed_threshold <= rows[i].thr;
            host.wr(rows[i].addr, rows[i].data, 1'b0);
            if (rows[i].addr == `MDC_ADDR_DRIVE_CFG)
                drive_w = rows[i].exp_rd;
            else
                detect_w = rows[i].exp_rd;
            repeat (2) @(posedge clk);
            #1;
            check_settings();
            check("threshold speed", 40'(closed_loop_speed_mhz), 40'(rows[i].exp_speed));
            read_check(rows[i].addr, rows[i].exp_rd);
        end
        // Settings must still hold the old word just after the edge that stores the write and switch on the next.
        host.wr(`MDC_ADDR_DRIVE_CFG, 16'h8000, 1'b0);
        #1;
        check("settings before update", 40'(drive_set), 40'(exp_drive(drive_w)));
        drive_w = 16'h8000;
        @(posedge clk);
        #1;
        check("settings after update", 40'(drive_set), 40'(exp_drive(drive_w)));
        // A write to an unmapped address must change nothing and read back zero.
        host.wr(8'h97, 16'hFFFF, 1'b0);
        repeat (2) @(posedge clk);
        #1;
        check_settings();
        read_check(8'h97, 16'h0000);
        // The reserved bit is forced here on purpose; it must neither store nor decode.
        host.wr(`MDC_ADDR_DETECT_CFG, 16'hFFFF, 1'b1);
        detect_w = 16'hFF7F;
        repeat (2) @(posedge clk);
        #1;
        check_settings();
        read_check(`MDC_ADDR_DETECT_CFG, 16'hFF7F);
        // A reset in mid-run returns both words to zero.
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        drive_w  = 16'h0000;
        detect_w = 16'h0000;
        repeat (3) @(posedge clk);
        #1;
        check_settings();
        read_check(`MDC_ADDR_DRIVE_CFG, 16'h0000);
        read_check(`MDC_ADDR_DETECT_CFG, 16'h0000);
        give_verdict();
    end
endmodule : mdc_bank_tb_top
`default_nettype wire
